// ===== hdl/actuator_status_output_logic.sv
// What this block does
// - Mode status high in manual, low automatic
// - Show reached position number after move completes
// - Moving flag follows motor operation
// - In-position when within completed width of target
// - Ready flag follows servo on
// - Teach status high in teach mode
// - Write complete pulses for 30 ms once the write is stored
// - Write complete low in regular mode
// - Home done after home return completes
// - Area flag within parameter upper/lower bounds
// - Position area within program step range
// - Estop status high normally, low when opened
// - Load flag after sustained torque over threshold
// - Torque flag at threshold while moving
// - Cylinder arrival output for completed position
// - Three detect outputs within the in-position width of their points
// - Teach mode while teach input high
// - Manual mode while mode input high
`timescale 1ns/1ps
module actuator_status_output_logic #(
  parameter int unsigned POS_W = act_status_pkg::POS_W,
  parameter int unsigned PNUM_W = act_status_pkg::PNUM_W,
  parameter int unsigned TRQ_W = act_status_pkg::TRQ_W,
  parameter int unsigned CNT_W = act_status_pkg::CNT_W,
  parameter int unsigned WRITE_DONE_CYCLES = act_status_pkg::WRITE_DONE_CYCLES,
  parameter int unsigned WRITE_HOLD_CYCLES = act_status_pkg::WRITE_HOLD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_srst,
  // Host inputs
  input wire logic i_manual_mode_select,
  input wire logic i_teach_mode_select,
  input wire logic i_current_position_write,
  input wire logic i_alarm_reset,
  input wire logic i_cylinder_mode,
  // Motion core status
  input wire logic i_motor_running,
  input wire logic i_servo_on,
  input wire logic i_move_done,
  input wire logic [PNUM_W-1:0] i_move_pos_num,
  input wire logic i_home_done,
  input wire logic i_estop_open,
  input wire logic i_alarm_event,
  input wire logic i_write_stored,
  input wire logic [POS_W-1:0] i_cur_pos,
  input wire logic [POS_W-1:0] i_target_pos,
  input wire logic [POS_W-1:0] i_inpos_width,
  input wire logic [POS_W-1:0] i_area_lower,
  input wire logic [POS_W-1:0] i_area_upper,
  input wire logic [POS_W-1:0] i_step_lower,
  input wire logic [POS_W-1:0] i_step_upper,
  input wire logic [POS_W-1:0] i_detect_pos0,
  input wire logic [POS_W-1:0] i_detect_pos1,
  input wire logic [POS_W-1:0] i_detect_pos2,
  input wire logic [TRQ_W-1:0] i_torque_cmd,
  input wire logic [TRQ_W-1:0] i_load_threshold,
  input wire logic [TRQ_W-1:0] i_torque_threshold,
  input wire logic [CNT_W-1:0] i_load_time,
  input wire logic [POS_W-1:0] i_judge_lower,
  input wire logic [POS_W-1:0] i_judge_upper,
  // Host outputs
  output logic o_manual_mode_status,
  output logic o_teach_mode_status,
  output logic [PNUM_W-1:0] o_end_position_code,
  output logic o_moving_flag,
  output logic o_in_position_flag,
  output logic o_operation_ready_flag,
  output logic o_alarm_flag,
  output logic o_write_complete_pulse,
  output logic o_home_done_flag,
  output logic o_area_flag,
  output logic o_position_area_flag,
  output logic o_estop_status,
  output logic o_load_flag,
  output logic o_torque_level_flag,
  output logic [act_status_pkg::ARRIVE_N-1:0] o_cylinder_arrival_outputs,
  output logic [act_status_pkg::DETECT_N-1:0] o_cylinder_detect_outputs,
  output logic o_write_request
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic in_range(input logic [POS_W-1:0] p, input logic [POS_W-1:0] lo,
                                    input logic [POS_W-1:0] hi);
    in_range = (p >= lo) && (p <= hi);
  endfunction

  // Distance compare avoids signed wrap: take the larger minus the smaller
  function automatic logic near_point(input logic [POS_W-1:0] p, input logic [POS_W-1:0] c,
                                      input logic [POS_W-1:0] w);
    logic [POS_W-1:0] d;
    d = (p >= c) ? (p - c) : (c - p);
    near_point = (d <= w);
  endfunction

  // ****************************************
  // Decoding
  // ****************************************
  typedef enum logic [1:0] {WR_IDLE, WR_HOLD, WR_WAIT, WR_PULSE} write_state_e;
  write_state_e wr_state;
  write_state_e next_wr_state;
  logic [CNT_W-1:0] wr_count;
  logic hold_done;

  wire in_pos = near_point(i_cur_pos, i_target_pos, i_inpos_width);
  wire in_area = in_range(i_cur_pos, i_area_lower, i_area_upper);
  wire in_step = in_range(i_cur_pos, i_step_lower, i_step_upper);
  wire in_judge = in_range(i_cur_pos, i_judge_lower, i_judge_upper);
  wire load_over = in_judge && (i_torque_cmd > i_load_threshold);
  wire [act_status_pkg::DETECT_N-1:0] near_det = {
    near_point(i_cur_pos, i_detect_pos2, i_inpos_width),
    near_point(i_cur_pos, i_detect_pos1, i_inpos_width),
    near_point(i_cur_pos, i_detect_pos0, i_inpos_width)};
  wire arrive_valid = i_move_pos_num < PNUM_W'(act_status_pkg::ARRIVE_N);
  wire [act_status_pkg::ARRIVE_N-1:0] arrive_onehot =
    arrive_valid ? act_status_pkg::ARRIVE_N'(1) << i_move_pos_num : '0;
  wire hold_expired = (wr_count >= CNT_W'(WRITE_HOLD_CYCLES - 1));
  wire pulse_expired = (wr_count >= CNT_W'(WRITE_DONE_CYCLES - 1));

  // ****************************************
  // Load judgment timer
  // ****************************************
  hold_counter #(
    .W(CNT_W)
  ) u_load_timer (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_run(load_over),
    .i_limit(i_load_time),
    .o_expired(hold_done)
  );

  // ****************************************
  // Position write sequencing
  // ****************************************
  // Leaving teach mode aborts any write in flight
  always_comb
  begin
    next_wr_state = wr_state;
    if (!i_teach_mode_select)
      next_wr_state = WR_IDLE;
    else
    begin
      case (wr_state)
        WR_IDLE:
          if (i_current_position_write)
            next_wr_state = WR_HOLD;
        WR_HOLD:
          if (!i_current_position_write)
            next_wr_state = WR_IDLE;
          else if (hold_expired)
            next_wr_state = WR_WAIT;
        WR_WAIT:
          if (i_write_stored)
            next_wr_state = WR_PULSE;
        WR_PULSE:
          if (pulse_expired)
            next_wr_state = WR_IDLE;
        default:
          next_wr_state = WR_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      wr_state <= WR_IDLE;
      wr_count <= '0;
    end
    else
    begin
      wr_state <= next_wr_state;
      wr_count <= (next_wr_state != wr_state) ? '0 : wr_count + CNT_W'(1);
    end
  end

  // ****************************************
  // Next values of the status outputs
  // ****************************************
  wire next_torque_level = i_motor_running && (i_torque_cmd >= i_torque_threshold);
  wire next_load = hold_done && load_over;
  // Set wins over a reset in the same cycle
  wire next_alarm = i_alarm_event || (o_alarm_flag && !i_alarm_reset);
  wire [PNUM_W-1:0] next_end_code = i_move_done ? i_move_pos_num : o_end_position_code;
  // Home done stays set until reset: one finished homing is enough for the host
  wire next_home_done = i_home_done || o_home_done_flag;
  // Arrival clears as the motor starts again, so a stale arrival never shows
  wire arrival_clear = !i_cylinder_mode || (i_motor_running && !i_move_done);
  wire [act_status_pkg::ARRIVE_N-1:0] next_arrival =
    arrival_clear ? '0 : (i_move_done ? arrive_onehot : o_cylinder_arrival_outputs);
  wire [act_status_pkg::DETECT_N-1:0] next_detect = i_cylinder_mode ? near_det : '0;
  wire next_write_pulse = (next_wr_state == WR_PULSE) && i_teach_mode_select;
  wire next_write_request = (next_wr_state == WR_WAIT);

  // ****************************************
  // Mode and level outputs
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_manual_mode_status <= 1'h0;
    else
      o_manual_mode_status <= i_manual_mode_select;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_teach_mode_status <= 1'h0;
    else
      o_teach_mode_status <= i_teach_mode_select;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_moving_flag <= 1'h0;
    else
      o_moving_flag <= i_motor_running;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_in_position_flag <= 1'h0;
    else
      o_in_position_flag <= in_pos;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_operation_ready_flag <= 1'h0;
    else
      o_operation_ready_flag <= i_servo_on;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_area_flag <= 1'h0;
    else
      o_area_flag <= in_area;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_position_area_flag <= 1'h0;
    else
      o_position_area_flag <= in_step;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_estop_status <= act_status_pkg::ESTOP_STATUS_RST;
    else
      o_estop_status <= !i_estop_open;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_torque_level_flag <= 1'h0;
    else
      o_torque_level_flag <= next_torque_level;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_load_flag <= 1'h0;
    else
      o_load_flag <= next_load;
  end

  // ****************************************
  // Event outputs
  // ****************************************
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_end_position_code <= act_status_pkg::END_CODE_RST;
    else
      o_end_position_code <= next_end_code;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_home_done_flag <= 1'h0;
    else
      o_home_done_flag <= next_home_done;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_alarm_flag <= 1'h0;
    else
      o_alarm_flag <= next_alarm;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_cylinder_arrival_outputs <= '0;
    else
      o_cylinder_arrival_outputs <= next_arrival;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_cylinder_detect_outputs <= '0;
    else
      o_cylinder_detect_outputs <= next_detect;
  end

  // Dropping teach mode kills the pulse on the next edge
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_write_complete_pulse <= 1'h0;
    else
      o_write_complete_pulse <= next_write_pulse;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      o_write_request <= 1'h0;
    else
      o_write_request <= next_write_request;
  end

endmodule

// ===== include/act_status_pkg.sv
package act_status_pkg;
  // Clock rate in Hz
  localparam int unsigned CLK_HZ = 25_000_000;
  // Write-complete pulse length in ms, and its cycle count
  localparam int unsigned WRITE_DONE_MS = 30;
  localparam int unsigned WRITE_DONE_CYCLES = (CLK_HZ / 1000) * WRITE_DONE_MS;
  // Least hold time of the position-write request in ms, and its cycle count
  localparam int unsigned WRITE_HOLD_MS = 20;
  localparam int unsigned WRITE_HOLD_CYCLES = (CLK_HZ / 1000) * WRITE_HOLD_MS + 1;
  // Widths
  localparam int unsigned POS_W = 24;
  localparam int unsigned PNUM_W = 8;
  localparam int unsigned TRQ_W = 16;
  localparam int unsigned ARRIVE_N = 7;
  localparam int unsigned DETECT_N = 3;
  localparam int unsigned CNT_W = 24;
  // Reset values of the status outputs
  localparam logic ESTOP_STATUS_RST = 1'h0;
  localparam logic [PNUM_W-1:0] END_CODE_RST = 8'h00;
endpackage

// ===== hdl/hold_counter.sv
`timescale 1ns/1ps
// Counts cycles while a condition holds; flags once the limit is passed
module hold_counter #(
  parameter int unsigned W = 24
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_run,
  input wire logic [W-1:0] i_limit,
  output logic o_expired
);
  logic [W-1:0] count;
  wire at_limit = (count >= i_limit);
  always_ff @(posedge i_clk)
  begin
    if (i_srst || !i_run)
    begin
      count <= '0;
      o_expired <= 1'h0;
    end
    else
    begin
      if (!at_limit)
        count <= count + W'(1);
      o_expired <= at_limit;
    end
  end
endmodule

// ===== test/core_store_model.sv
`timescale 1ns/1ps
// *****
// Motion core side of the position write
// *****
module core_store_model #(
  parameter int unsigned DELAY = 3
) (
  input wire logic i_clk,
  input wire logic i_request,
  output logic o_stored
);
  int unsigned wait_cnt = 0;
  initial o_stored = 1'b0;
  // Answers late on purpose, so the request must stand until stored
  always @(posedge i_clk)
  begin
    o_stored <= 1'b0;
    if (!i_request || o_stored)
      wait_cnt <= 0;
    else if (wait_cnt == DELAY)
      o_stored <= 1'b1;
    else
      wait_cnt <= wait_cnt + 1;
  end
endmodule

// ===== test/actuator_status_sva.sv
`timescale 1ns/1ps
// *****
// Status output checks
// *****
module actuator_status_sva #(
  parameter int unsigned WRITE_DONE_CYCLES = 10
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_manual_mode_select,
  input wire logic i_teach_mode_select,
  input wire logic i_servo_on,
  input wire logic i_estop_open,
  input wire logic i_move_done,
  input wire logic [7:0] i_move_pos_num,
  input wire logic i_alarm_event,
  input wire logic i_alarm_reset,
  input wire logic o_manual_mode_status,
  input wire logic o_operation_ready_flag,
  input wire logic o_estop_status,
  input wire logic [7:0] o_end_position_code,
  input wire logic o_write_complete_pulse,
  input wire logic o_alarm_flag
);
  int unsigned run_len;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  always_ff @(posedge i_clk)
    run_len <= (i_srst || !o_write_complete_pulse) ? 0 : run_len + 1;
  sequence s_live;
    !$past(i_srst);
  endsequence
  chk_manual_mode: assert property (s_live |-> o_manual_mode_status == $past(i_manual_mode_select))
    else $error("manual status wrong");
  chk_ready_flag: assert property (s_live |-> o_operation_ready_flag == $past(i_servo_on))
    else $error("ready flag wrong");
  chk_estop_status: assert property (s_live |-> o_estop_status == !$past(i_estop_open))
    else $error("estop status wrong");
  chk_end_code: assert property (i_move_done |=> o_end_position_code == $past(i_move_pos_num))
    else $error("end code not latched");
  chk_code_hold: assert property (!i_move_done |=> $stable(o_end_position_code))
    else $error("end code changed");
  chk_pulse_regular: assert property (s_live ##0 !$past(i_teach_mode_select) |-> !o_write_complete_pulse)
    else $error("write pulse outside teach");
  chk_pulse_length: assert property ($fell(o_write_complete_pulse) && !$past(i_srst)
    && $past(i_teach_mode_select) |-> run_len == WRITE_DONE_CYCLES)
    else $error("write pulse length wrong");
  chk_alarm_set: assert property (i_alarm_event |=> o_alarm_flag)
    else $error("alarm not raised");
  chk_alarm_hold: assert property (o_alarm_flag && !i_alarm_reset |=> o_alarm_flag)
    else $error("alarm dropped");
endmodule
bind actuator_status_output_logic actuator_status_sva #(
  .WRITE_DONE_CYCLES(WRITE_DONE_CYCLES)
) actuator_status_sva_i (.*);

// ===== test/actuator_status_output_logic_test.sv
`timescale 1ns/1ps
// *****
// Status output bench
// *****
module actuator_status_output_logic_test;
  localparam int unsigned WD = 10;
  localparam int unsigned WH = 5;
  logic i_clk = 0, i_srst = 1, i_manual_mode_select = 0, i_teach_mode_select = 0;
  logic i_current_position_write = 0, i_alarm_reset = 0, i_cylinder_mode = 0;
  logic i_motor_running = 0, i_servo_on = 0, i_move_done = 0, i_home_done = 0;
  logic i_estop_open = 0, i_alarm_event = 0, i_write_stored;
  logic [7:0] i_move_pos_num = 8'h00;
  logic [23:0] i_cur_pos = 24'h000064, i_target_pos = 24'h000069, i_inpos_width = 24'h000005;
  logic [23:0] i_area_lower = 24'h000064, i_area_upper = 24'h000064, i_step_lower = 24'h000065;
  logic [23:0] i_step_upper = 24'h0000C8, i_detect_pos0 = 24'h000000, i_detect_pos1 = 24'h000069;
  logic [23:0] i_detect_pos2 = 24'h000100, i_judge_lower = 24'h000000, i_judge_upper = 24'h000000;
  logic [23:0] i_load_time = 24'h000004;
  logic [15:0] i_torque_cmd = 16'h0010, i_load_threshold = 16'h0020, i_torque_threshold = 16'h0010;
  logic o_manual_mode_status, o_teach_mode_status, o_moving_flag, o_in_position_flag;
  logic o_operation_ready_flag, o_alarm_flag, o_write_complete_pulse, o_home_done_flag;
  logic o_area_flag, o_position_area_flag, o_estop_status, o_load_flag, o_torque_level_flag;
  logic o_write_request;
  logic [7:0] o_end_position_code;
  logic [6:0] o_cylinder_arrival_outputs;
  logic [2:0] o_cylinder_detect_outputs;
  int n_mismatch = 0, num_checks = 0, n;
  actuator_status_output_logic #(
    .WRITE_DONE_CYCLES(WD),
    .WRITE_HOLD_CYCLES(WH)
  ) actuator_status_output_logic_i (.*);
  core_store_model core_store_model_i (
    .i_clk(i_clk),
    .i_request(o_write_request),
    .o_stored(i_write_stored)
  );
  initial
    forever #20 i_clk = ~i_clk;
  task automatic tick(input int c);
    repeat (c) @(negedge i_clk);
  endtask
  task automatic cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is under two hundred cycles
  initial
  begin
    repeat (3000) @(posedge i_clk);
    n_mismatch++;
    print_verdict();
  end
  initial
  begin
    tick(16);
    i_srst = 0;
    for (int v = 0; v < 2; v++)
    begin
      {i_manual_mode_select, i_teach_mode_select, i_servo_on, i_motor_running} = {4{v[0]}};
      i_estop_open = !v[0];
      tick(2);
      cmp("manual", v, o_manual_mode_status);
      cmp("teach", v, o_teach_mode_status);
      cmp("ready", v, o_operation_ready_flag);
      cmp("moving", v, o_moving_flag);
      cmp("estop", v, o_estop_status);
    end
    cmp("torque", 1, o_torque_level_flag);
    cmp("inpos", 1, o_in_position_flag);
    cmp("area", 1, o_area_flag);
    cmp("parea", 0, o_position_area_flag);
    i_inpos_width = 24'h000004;
    tick(2);
    cmp("inpos_out", 0, o_in_position_flag);
    $display("end of mode test");
    i_current_position_write = 1;
    tick(2);
    i_current_position_write = 0;
    tick(WH + 2);
    cmp("short_write", 0, o_write_request);
    for (int k = 0; k < 2; k++)
    begin
      i_current_position_write = 1;
      n = 0;
      while (o_write_request !== 1'h1 && n < 50)
      begin
        tick(1);
        n++;
      end
      cmp("hold_ok", 1, n >= WH);
      i_current_position_write = 0;
      n = 0;
      while (o_write_complete_pulse !== 1'h1 && n < 50)
      begin
        tick(1);
        n++;
      end
      n = 0;
      if (k == 1)
        i_teach_mode_select = 0;
      while (o_write_complete_pulse === 1'h1 && n < 50)
      begin
        tick(1);
        n++;
      end
      cmp("write_complete_pulse_len", k ? 1 : WD, n);
    end
    $display("end of write test");
    i_alarm_event = 1;
    i_home_done = 1;
    tick(1);
    i_alarm_event = 0;
    i_home_done = 0;
    tick(4);
    cmp("alarm", 1, o_alarm_flag);
    cmp("home", 1, o_home_done_flag);
    i_alarm_reset = 1;
    tick(2);
    cmp("alarm_clr", 0, o_alarm_flag);
    $display("end of alarm test");
    i_motor_running = 0;
    i_cylinder_mode = 1;
    i_inpos_width = 24'h000005;
    i_move_pos_num = 8'h03;
    i_move_done = 1;
    tick(1);
    i_move_done = 0;
    i_move_pos_num = 8'hA5;
    tick(3);
    cmp("code_hold", 8'h03, o_end_position_code);
    cmp("arrival", 8'h08, o_cylinder_arrival_outputs);
    cmp("detect", 8'h02, o_cylinder_detect_outputs);
    i_move_done = 1;
    tick(1);
    i_move_done = 0;
    tick(1);
    cmp("code_new", 8'hA5, o_end_position_code);
    $display("end of position test");
    i_judge_upper = 24'h000100;
    i_torque_cmd = 16'h0030;
    tick(5);
    cmp("load_early", 0, o_load_flag);
    tick(1);
    cmp("load", 1, o_load_flag);
    cmp("torque_idle", 0, o_torque_level_flag);
    i_torque_cmd = 16'h0010;
    tick(2);
    cmp("load_off", 0, o_load_flag);
    $display("end of load test");
    print_verdict();
  end
endmodule
